// ==== pkg/sccu_pkg.sv ====
// Purpose: shared constants for the status and common command unit
// Assumes: classic wishbone register access, 32-bit data
// Notes:   command codes are written into the command register
package sccu_pkg;

  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int          ADR_W        = 8;
  localparam int          DAT_W        = 32;
  localparam logic [7:0]  OFF_CMD      = 8'h00;
  localparam logic [7:0]  OFF_REPLY    = 8'h04;
  localparam logic [7:0]  OFF_ESR      = 8'h08;
  localparam logic [7:0]  OFF_STAT     = 8'h0c;
  localparam logic [7:0]  OFF_ESE      = 8'h10;
  localparam logic [7:0]  OFF_SRE      = 8'h14;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h1c;

  // ------------------------------------------------------------
  // command codes, cmd register bits [3:0], argument in [15:8]
  // ------------------------------------------------------------
  localparam logic [3:0]  CMD_OPC      = 4'h1;
  localparam logic [3:0]  CMD_OPCQ     = 4'h2;
  localparam logic [3:0]  CMD_RST      = 4'h3;
  localparam logic [3:0]  CMD_SRE      = 4'h4;
  localparam logic [3:0]  CMD_SREQ     = 4'h5;
  localparam logic [3:0]  CMD_STBQ     = 4'h6;
  localparam logic [3:0]  CMD_TSTQ     = 4'h7;
  localparam logic [3:0]  CMD_WAI      = 4'h8;
  localparam logic [3:0]  CMD_ESRQ     = 4'h9;
  localparam int          CMD_CODE_LSB = 0;
  localparam int          CMD_ARG_LSB  = 8;

  // ------------------------------------------------------------
  // status byte and event register fields
  // ------------------------------------------------------------
  localparam int          STB_MAV      = 4;
  localparam int          STB_ESB      = 5;
  localparam int          STB_MSS      = 6;
  localparam int          STB_OSB      = 7;
  localparam int          ESR_OPC      = 0;
  localparam logic [7:0]  OPCQ_VALUE   = 8'h01;
  localparam logic [7:0]  SRE_RST      = 8'h00;
  localparam logic [7:0]  ESE_RST      = 8'h00;
  localparam logic [7:0]  ESR_RST      = 8'h00;
  localparam int          REPLY_VLD    = 8;

  // ------------------------------------------------------------
  // status word and interrupt bits
  // ------------------------------------------------------------
  localparam int          ST_SRQ       = 8;
  localparam int          ST_TSTF      = 9;
  localparam int          ST_HOLD      = 10;
  localparam int          ST_OPCARM    = 11;
  localparam int          IRQ_W        = 4;
  localparam int          IRQ_OPC      = 0;
  localparam int          IRQ_REPLY    = 1;
  localparam int          IRQ_SRQ      = 2;
  localparam int          IRQ_REFUSE   = 3;

  typedef enum logic [1:0] {
    SCCU_W_IDLE = 2'b01,
    SCCU_W_HOLD = 2'b10
  } sccu_wstate_t;

endpackage : sccu_pkg

// ==== rtl/sccu_wait.sv ====
// Purpose: hold-off tracker that waits for all pending operations
// Assumes: op_pending is synchronous to clk
// Notes:   done is a one-cycle pulse at the end of a hold
`timescale 1ns/1ns
`default_nettype none
module sccu_wait (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  input  wire logic op_pending,
  output logic      busy,
  output logic      done
);
  import sccu_pkg::*;

  sccu_wstate_t state_r;

  // ------------------------------------------------------------
  // hold state machine
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= SCCU_W_IDLE;
    end else begin
      unique case (state_r)
        SCCU_W_IDLE: begin
          if (start) begin
            state_r <= SCCU_W_HOLD;
          end
        end
        SCCU_W_HOLD: begin
          if (!op_pending) begin
            state_r <= SCCU_W_IDLE; // R11
          end
        end
        default: begin
          state_r <= SCCU_W_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_r == SCCU_W_HOLD);
  assign done = busy && !op_pending;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  hold_while_pending_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
    busy && op_pending |=> busy)
    else $error("hold released while operations pending");

  done_ends_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
    done |=> !busy)
    else $error("hold did not end after done");

endmodule : sccu_wait
`default_nettype wire

// ==== rtl/sccu_top.sv ====
// Purpose: common status and synchronisation command unit
// Assumes: commands arrive as codes over classic wishbone
// Notes:   single-entry output queue, one level interrupt
// How it works
// [R1] opc arms; event bit set once no selected operation is pending
// [R2] controller should send opc last in a command string
// [R3] opc query waits for completion, then queues value one
// [R4] reset command restores all controller parameters to power-up values
// [R5] enable argument is a bit-weight sum; set bit enables, clear disables
// [R6] status byte: message available bit4, event summary bit5, operation bit7
// [R7] enable query returns the current enable mask as weight sum
// [R8] status byte query returns flags and changes no register
// [R9] self-test query answers 0 for no errors, 1 for errors
// [R10] self-test answer comes from power-up test; query starts nothing
// [R11] wait command stalls further commands until nothing is pending; here commands written during the hold are refused and dropped
// [R12] end of wait leaves the completion event bit alone
// [R13] event register query returns the weight sum of set event bits
// [R14] event summary set while any enabled event bit is set
`timescale 1ns/1ns
`default_nettype none
module sccu_top (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [sccu_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [sccu_pkg::DAT_W-1:0]  wb_dat_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic                        wb_we_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  output logic      [sccu_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        op_pending,
  input  wire logic                        op_summary,
  input  wire logic [7:0]                  dev_evt,
  input  wire logic                        selftest_fail,
  output logic                             params_rst,
  output logic                             srq,
  output logic                             irq
);
  import sccu_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic              ack_r;
  logic [DAT_W-1:0]  dat_r;
  logic              acc;
  logic              wr;
  logic              rd;
  logic              cmd_wr;
  logic [3:0]        code;
  logic [7:0]        arg;
  logic              is_query;
  logic              known;
  logic              fire;
  logic              refuse;
  logic [7:0]        sre_r;
  logic [7:0]        ese_r;
  logic [7:0]        esr_r;
  logic [7:0]        reply_r;
  logic              reply_vld_r;
  logic              opc_arm_r;
  logic              hold_opcq_r;
  logic              tst_fail_r;
  logic              tst_taken_r;
  logic              rst_pulse_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic              srq_q_r;
  logic              reply_vld_q_r;
  logic              w_busy;
  logic              w_done;
  logic              w_start;
  logic              opc_hit;
  logic              esb;
  logic [7:0]        stb;
  logic [IRQ_W-1:0]  irq_evt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [DAT_W-1:0] zx8(input logic [7:0] v);
    zx8 = {{(DAT_W-8){1'b0}}, v};
  endfunction : zx8

  // ------------------------------------------------------------
  // wishbone slave, one wait state
  // ------------------------------------------------------------
  assign acc      = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr       = acc && wb_we_i;
  assign rd       = acc && !wb_we_i;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  assign cmd_wr   = wr && hit(wb_adr_i, OFF_CMD) && wb_sel_i[0];
  assign code     = wb_dat_i[CMD_CODE_LSB +: 4];
  assign arg      = wb_sel_i[1] ? wb_dat_i[CMD_ARG_LSB +: 8] : 8'h00;
  assign is_query = (code == CMD_OPCQ) || (code == CMD_SREQ) || (code == CMD_STBQ)
                 || (code == CMD_TSTQ) || (code == CMD_ESRQ);
  assign known    = is_query || (code == CMD_OPC) || (code == CMD_RST)
                 || (code == CMD_SRE) || (code == CMD_WAI);
  // refused while a hold runs or for an unknown code; a query needs an empty output queue
  assign refuse   = cmd_wr && (w_busy || !known || (is_query && reply_vld_r)); // R11
  assign fire     = cmd_wr && !refuse;
  assign w_start  = fire && ((code == CMD_WAI) || (code == CMD_OPCQ));

  sccu_wait u_wait (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (w_start),
    .op_pending (op_pending),
    .busy       (w_busy),
    .done       (w_done)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_opcq_r <= 1'b0;
    end else if (w_start) begin
      hold_opcq_r <= (code == CMD_OPCQ);
    end
  end

  // ------------------------------------------------------------
  // operation complete event
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opc_arm_r <= 1'b0;
    end else if (fire && code == CMD_OPC) begin
      opc_arm_r <= 1'b1;
    end else if (opc_hit) begin
      opc_arm_r <= 1'b0;
    end
  end

  assign opc_hit = opc_arm_r && !op_pending; // R1

  // event register; sets win over the clear by query, wait end touches nothing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      esr_r <= ESR_RST;
    end else begin
      esr_r <= ((fire && code == CMD_ESRQ) ? 8'h00 : esr_r) | dev_evt
             | (opc_hit ? (8'h01 << ESR_OPC) : 8'h00); // R1 R12
    end
  end

  // ------------------------------------------------------------
  // enable masks and parameter reset
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sre_r <= SRE_RST;
      ese_r <= ESE_RST;
    end else if (fire && code == CMD_RST) begin
      sre_r <= SRE_RST; // R4
      ese_r <= ESE_RST; // R4
    end else begin
      if (fire && code == CMD_SRE) begin
        sre_r <= arg; // R5
      end
      if (wr && hit(wb_adr_i, OFF_ESE) && wb_sel_i[0]) begin
        ese_r <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_pulse_r <= 1'b0;
    end else begin
      rst_pulse_r <= fire && (code == CMD_RST); // R4
    end
  end

  assign params_rst = rst_pulse_r;

  // ------------------------------------------------------------
  // power-up self-test capture
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tst_taken_r <= 1'b0;
      tst_fail_r  <= 1'b0;
    end else if (!tst_taken_r) begin
      tst_taken_r <= 1'b1;
      tst_fail_r  <= selftest_fail; // R10
    end
  end

  // ------------------------------------------------------------
  // status byte and service request
  // ------------------------------------------------------------
  assign esb = |(esr_r & ese_r); // R14
  always_comb begin
    stb          = 8'h00;
    stb[STB_MAV] = reply_vld_r; // R6
    stb[STB_ESB] = esb;         // R6
    stb[STB_OSB] = op_summary;  // R6
    stb[STB_MSS] = |(stb & sre_r & ~(8'h01 << STB_MSS)); // R5
  end
  assign srq = stb[STB_MSS];

  // ------------------------------------------------------------
  // output queue, one entry; a read of the reply register pops it
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reply_r     <= 8'h00;
      reply_vld_r <= 1'b0;
    end else if (w_done && hold_opcq_r) begin
      reply_r     <= OPCQ_VALUE; // R3
      reply_vld_r <= 1'b1;
    end else if (fire && is_query && code != CMD_OPCQ) begin
      reply_vld_r <= 1'b1;
      unique case (code)
        CMD_SREQ: reply_r <= sre_r;                 // R7
        CMD_STBQ: reply_r <= stb;                   // R8
        CMD_TSTQ: reply_r <= {7'h00, tst_fail_r};   // R9 R10
        default:  reply_r <= esr_r;                 // R13
      endcase
    end else if (rd && hit(wb_adr_i, OFF_REPLY)) begin
      reply_vld_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupts, write one to clear, set wins
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      srq_q_r       <= 1'b0;
      reply_vld_q_r <= 1'b0;
    end else begin
      srq_q_r       <= srq;
      reply_vld_q_r <= reply_vld_r;
    end
  end

  always_comb begin
    irq_evt             = '0;
    irq_evt[IRQ_OPC]    = opc_hit;
    irq_evt[IRQ_REPLY]  = reply_vld_r && !reply_vld_q_r;
    irq_evt[IRQ_SRQ]    = srq && !srq_q_r;
    irq_evt[IRQ_REFUSE] = refuse;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (wr && hit(wb_adr_i, OFF_IRQ_STAT) && wb_sel_i[0])
                  ? ((irq_stat_r & ~wb_dat_i[IRQ_W-1:0]) | irq_evt)
                  : (irq_stat_r | irq_evt);
      if (wr && hit(wb_adr_i, OFF_IRQ_MASK) && wb_sel_i[0]) begin
        irq_mask_r <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dat_r <= '0;
    end else if (rd) begin
      unique case (wb_adr_i)
        OFF_CMD:      dat_r <= {{(DAT_W-1){1'b0}}, w_busy};
        OFF_REPLY:    dat_r <= zx8(reply_r) | (DAT_W'(reply_vld_r) << REPLY_VLD);
        OFF_ESR:      dat_r <= zx8(esr_r); // R13
        OFF_STAT:     dat_r <= zx8(stb) | (DAT_W'(srq) << ST_SRQ)
                             | (DAT_W'(tst_fail_r) << ST_TSTF)
                             | (DAT_W'(w_busy) << ST_HOLD)
                             | (DAT_W'(opc_arm_r) << ST_OPCARM);
        OFF_ESE:      dat_r <= zx8(ese_r);
        OFF_SRE:      dat_r <= zx8(sre_r);
        OFF_IRQ_STAT: dat_r <= {{(DAT_W-IRQ_W){1'b0}}, irq_stat_r};
        OFF_IRQ_MASK: dat_r <= {{(DAT_W-IRQ_W){1'b0}}, irq_mask_r};
        default:      dat_r <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence opcq_start_s;
    fire && code == CMD_OPCQ;
  endsequence

  sequence hold_end_s;
    w_done && hold_opcq_r;
  endsequence

  ack_single_a: assert property (@(posedge clk) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  opc_event_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
    opc_arm_r && !op_pending |=> esr_r[ESR_OPC] && !opc_arm_r)
    else $error("completion event bit not set");

  opcq_reply_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
    opcq_start_s ##1 (w_busy && !op_pending) |=> reply_vld_r && reply_r == OPCQ_VALUE)
    else $error("opc query reply missing");

  opcq_wait_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
    hold_end_s |-> !reply_vld_r ##1 reply_vld_r)
    else $error("opc query reply early or lost");

  rst_restore_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
    fire && code == CMD_RST |=> sre_r == SRE_RST && ese_r == ESE_RST && params_rst)
    else $error("parameters not restored");

  sre_load_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
    fire && code == CMD_SRE |=> sre_r == $past(arg))
    else $error("enable mask not loaded");

  stb_layout_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
    stb[STB_MAV] == reply_vld_r && stb[STB_OSB] == op_summary)
    else $error("status byte layout wrong");

  sre_query_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
    fire && code == CMD_SREQ |=> reply_r == $past(sre_r) && reply_vld_r)
    else $error("enable query reply wrong");

  stb_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
    fire && code == CMD_STBQ && dev_evt == 8'h00 && !opc_hit
    |=> $stable(esr_r) && $stable(sre_r) && reply_r == $past(stb))
    else $error("status query disturbed registers");

  tst_reply_a: assert property (@(posedge clk) disable iff (sys_rst) // R9
    fire && code == CMD_TSTQ |=> reply_r == {7'h00, tst_fail_r} && $stable(tst_fail_r))
    else $error("self-test reply wrong");

  wai_stall_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
    cmd_wr && w_busy |-> refuse && !fire)
    else $error("command taken during hold");

  wai_esr_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
    w_done && !hold_opcq_r && !opc_hit && dev_evt == 8'h00 |=> $stable(esr_r))
    else $error("wait end touched event register");

  esr_query_a: assert property (@(posedge clk) disable iff (sys_rst) // R13
    fire && code == CMD_ESRQ |=> reply_r == $past(esr_r))
    else $error("event query reply wrong");

  esb_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
    stb[STB_ESB] == |(esr_r & ese_r))
    else $error("event summary wrong");

endmodule : sccu_top
`default_nettype wire

// ==== test/sccu_op_model.sv ====
// Purpose: far side model that drives the pending operation flag
// Assumes: go is a one-cycle pulse with len valid beside it
// Notes:   pending stays high for len cycles after go
`timescale 1ns/1ns
`default_nettype none
module sccu_op_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        go,
  input  wire logic [7:0]  len,
  output logic             op_pending
);
  logic [7:0] cnt_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
    end else if (go) begin
      cnt_r <= len;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  assign op_pending = (cnt_r != 8'h00);
endmodule : sccu_op_model
`default_nettype wire

// ==== test/sccu_top_bench.sv ====
// Purpose: self-checking bench for the status and common command unit
// Assumes: one clock, wishbone master tasks, reply popped after each query
// Notes:   expected values come from small integer models below
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  $display("Error %s exp %h got %h", nm, ex, gt); num_errors++; end end
module sccu_top_bench;
  import sccu_pkg::*;
  logic        clk, sys_rst, we, cyc, stb, ack, op_pending, op_summary;
  logic        selftest_fail, params_rst, srq, irq, go;
  logic [7:0]  adr, dev_evt, len;
  logic [31:0] dat, dat_o, rv;
  logic [3:0]  sel;
  int          num_errors, n_compared, cyc_cnt, rst_seen, m_esr, v, ese, a;

  sccu_top sccu_top_i (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .op_pending(op_pending), .op_summary(op_summary),
    .dev_evt(dev_evt), .selftest_fail(selftest_fail), .params_rst(params_rst),
    .srq(srq), .irq(irq));
  sccu_op_model sccu_op_model_i (.clk(clk), .sys_rst(sys_rst), .go(go), .len(len),
    .op_pending(op_pending));

  // ------------------------------------------------------------
  // clock, timeout and pulse watch
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (params_rst === 1'b1) rst_seen++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    adr <= ad; dat <= d; we <= w; cyc <= 1'b1; stb <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1);
    rv = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic cmd(input logic [3:0] c, input logic [7:0] arg);
    xfer(1'b1, OFF_CMD, {16'h0, arg, 4'h0, c});
  endtask : cmd
  task automatic query(input logic [3:0] c, input logic [7:0] arg);
    cmd(c, arg);
    xfer(1'b0, OFF_REPLY, 32'h0);
  endtask : query
  task automatic settle();
    for (int i = 0; i < 200 && op_pending !== 1'b0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic start_ops(input logic [7:0] n);
    go <= 1'b1; len <= n;
    @(posedge clk);
    go <= 1'b0;
  endtask : start_ops

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {we, cyc, stb, op_summary, go, dev_evt, len, adr, dat} = '0;
    sel = 4'hf; selftest_fail = 1'b1; sys_rst = 1'b1; m_esr = 0;
    v = $urandom(32'ha00e);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    selftest_fail <= 1'b0;
    query(CMD_TSTQ, 8'h00);
    `CHK("tst", 32'h101, rv)
    query(CMD_TSTQ, 8'h00);
    `CHK("tst again", 32'h101, rv)
    xfer(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rv)
    $display("test selftest done");
    for (int k = 0; k < 3; k++) begin
      v = $urandom & 32'hbf; ese = $urandom & 32'hff; a = $urandom & 32'hff;
      op_summary <= a[0];
      cmd(CMD_SRE, v[7:0]);
      xfer(1'b0, OFF_SRE, 32'h0);
      `CHK("sre reg", v, rv)
      query(CMD_SREQ, 8'h00);
      `CHK("sre query", v | 32'h100, rv)
      xfer(1'b1, OFF_ESE, ese);
      dev_evt <= a[7:0];
      @(posedge clk);
      dev_evt <= 8'h00;
      m_esr |= a;
      query(CMD_STBQ, 8'h00);
      `CHK("stb", {a[0], 1'b0, |(m_esr & ese), 5'h0} | 32'h100, rv & 32'h1a0)
      xfer(1'b0, OFF_STAT, 32'h0);
      `CHK("stat", {a[0], 1'b0, |(m_esr & ese), 5'h0}, rv & 32'ha0)
      `CHK("srq", (a[0] & v[7]) | ((|(m_esr & ese)) & v[5]), srq)
      xfer(1'b0, OFF_ESR, 32'h0);
      `CHK("esr kept", m_esr, rv)
      query(CMD_ESRQ, 8'h00);
      `CHK("esr query", m_esr | 32'h100, rv)
      m_esr = 0;
    end
    $display("test status done");
    start_ops(8'd20);
    cmd(CMD_OPC, 8'h00);
    xfer(1'b0, OFF_ESR, 32'h0);
    `CHK("opc early", 32'h0, rv & 32'h1)
    settle();
    xfer(1'b0, OFF_ESR, 32'h0);
    `CHK("opc set", 32'h1, rv & 32'h1)
    xfer(1'b1, OFF_IRQ_MASK, 32'h0);
    a = irq;
    xfer(1'b1, OFF_IRQ_MASK, 32'hf);
    `CHK("irq mask", 1'b1, a[0] ^ irq)
    xfer(1'b1, OFF_IRQ_STAT, 32'hf);
    xfer(1'b0, OFF_IRQ_STAT, 32'h0);
    `CHK("irq clear", 32'h0, rv)
    `CHK("irq low", 1'b0, irq)
    query(CMD_ESRQ, 8'h00);
    $display("test opc done");
    start_ops(8'd20);
    cmd(CMD_WAI, 8'h00);
    cmd(CMD_SRE, 8'h10);
    xfer(1'b0, OFF_CMD, 32'h0);
    `CHK("hold busy", 32'h1, rv & 32'h1)
    xfer(1'b0, OFF_IRQ_STAT, 32'h0);
    `CHK("refused", 32'h8, rv & 32'h8)
    xfer(1'b0, OFF_SRE, 32'h0);
    `CHK("sre held", v, rv)
    settle();
    xfer(1'b0, OFF_ESR, 32'h0);
    `CHK("wai no opc", 32'h0, rv & 32'h1)
    cmd(CMD_SRE, 8'h10);
    xfer(1'b0, OFF_SRE, 32'h0);
    `CHK("sre after", 32'h10, rv)
    $display("test wait done");
    start_ops(8'd20);
    cmd(CMD_OPCQ, 8'h00);
    xfer(1'b0, OFF_REPLY, 32'h0);
    `CHK("opcq early", 32'h0, rv & 32'h100)
    settle();
    xfer(1'b0, OFF_REPLY, 32'h0);
    `CHK("opcq reply", 32'h101, rv)
    query(CMD_OPCQ, 8'h00);
    `CHK("opcq idle", 32'h101, rv)
    $display("test opc query done");
    xfer(1'b1, OFF_ESE, 32'h5a);
    a = rst_seen;
    cmd(CMD_RST, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("rst pulse", a + 1, rst_seen)
    xfer(1'b0, OFF_SRE, 32'h0);
    `CHK("rst sre", 32'h0, rv)
    xfer(1'b0, OFF_ESE, 32'h0);
    `CHK("rst ese", 32'h0, rv)
    $display("test reset done");
    conclude();
  end
endmodule : sccu_top_bench
`default_nettype wire
